// ### core/disp_pkg.sv
// Constants and types for the display controller serial access port
// Function
// - Answer only addresses 0111100 or 0111101
// - Address low bit follows its strap pin
// - Acknowledge match, ignore other transfers whole
// - Stream is control byte then data byte
// - Cleared chain flag: only data bytes follow
// - Set chain flag: one data, then control
// - Select flag 1 to RAM, 0 to commands
// - RAM writes at pointer, pointer auto advances
// - Command bytes decoded into device settings
// - Acknowledge every byte, only when addressed
// - Read returns RAM or status per flag
// - Master no-acknowledge ends read, releases data
// - High select writes RAM, low writes command
// - Display RAM holds 160 x 160 bits
// - Page set by command, vertical mode increments
// - Column and page counters are independent
// - Scan direction reverses common line mapping
// - Oscillator select picks internal or external tick
// - Reset turns display and drivers off
// - Reset selects 160 line, normal segment map
// - Reset clears shifter, column, contrast 80H
// - Page mode column wraps, page kept
// - Vertical mode page wraps, column kept
package disp_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int OSC_PERIOD_NS = 1000;
	localparam int OSC_DIV = OSC_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [5:0] SLAVE_ADDR_HI = 6'h1E;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;
	localparam logic [7:0] COL_FIRST = 8'h00;
	localparam logic [7:0] COL_LAST = 8'h9F;
	localparam logic [4:0] PAGE_FIRST = 5'h00;
	localparam logic [4:0] PAGE_LAST = 5'h13;
	localparam logic [7:0] LINE_LAST = 8'h9F;
	localparam logic [7:0] MUX_RST = 8'h9F;
	localparam logic [7:0] CONTRAST_RST = 8'h80;
	localparam int RAM_BYTES = 3200;
	localparam logic [11:0] PAGE_BYTES = 12'h0A0;
	localparam logic [3:0] CMD_COL_LO = 4'h0;
	localparam logic [3:0] CMD_COL_HI = 4'h1;
	localparam logic [3:0] COL_HI_MAX = 4'h9;
	localparam logic [7:0] CMD_MODE_PAGE = 8'h20;
	localparam logic [7:0] CMD_MODE_VERT = 8'h21;
	localparam logic [7:0] CMD_CONTRAST = 8'h81;
	localparam logic [7:0] CMD_SEG_NORM = 8'hA0;
	localparam logic [7:0] CMD_SEG_REV = 8'hA1;
	localparam logic [7:0] CMD_ALL_OFF = 8'hA4;
	localparam logic [7:0] CMD_ALL_ON = 8'hA5;
	localparam logic [7:0] CMD_NORMAL = 8'hA6;
	localparam logic [7:0] CMD_INVERSE = 8'hA7;
	localparam logic [7:0] CMD_DISP_OFF = 8'hAE;
	localparam logic [7:0] CMD_DISP_ON = 8'hAF;
	localparam logic [7:0] CMD_PAGE_SET = 8'hB0;
	localparam logic [7:0] CMD_SCAN_NORM = 8'hC0;
	localparam logic [7:0] CMD_SCAN_REV = 8'hC8;
	localparam int STAT_OFF_BIT = 6;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_SETTINGS = 8'h08;
	localparam logic [7:0] REG_LINE = 8'h0C;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_SCAN_BIT = 1;
	localparam int ST_PAGE_LSB = 0;
	localparam int ST_COL_LSB = 8;
	localparam int ST_VERT_BIT = 16;
	localparam int ST_DC_BIT = 17;
	localparam int ST_BUSY_BIT = 18;
	localparam int ST_COM_LSB = 24;
	localparam int SET_SEG_BIT = 8;
	localparam int SET_ALL_BIT = 9;
	localparam int SET_INV_BIT = 10;
	localparam int SET_ON_BIT = 11;
	localparam int SET_MUX_LSB = 16;
	typedef enum logic [2:0] {PH_IDLE, PH_RX, PH_ACK, PH_TX, PH_TXACK, PH_IGNORE} phase_e;
	typedef enum logic [1:0] {K_ADDR, K_CTRL, K_DATA} kind_e;
	typedef enum logic [1:0] {P_NONE, P_CONTRAST, P_PAGE} pend_e;
endpackage

// ### core/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int W = 1
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_out
);
	// First stage feeds only the second stage
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_s;
	sync_s q;
	sync_s n;

	// Shift the pins one stage per clock
	always_comb
	begin
		n.s1 = pin_in;
		n.s2 = q.s1;
	end

	// Constant reset keeps the chain free of port values
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '0;
		else
			q <= n;
	end

	assign pin_out = q.s2;
endmodule
`default_nettype wire

// ### core/disp_i2c_port.sv
// Two-wire slave front end with display RAM, command decoder and APB view
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module disp_i2c_port #(
	parameter int OSC_DIV = disp_pkg::OSC_DIV
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic slave_addr_low_bit_pin,
	input wire logic osc_enable_select,
	input wire logic ext_display_tick_in,
	output logic display_tick,
	output logic panel_drive_en,
	output logic scan_reverse,
	output logic seg_remap
);
	// Whole module state
	typedef struct packed {
		disp_pkg::phase_e ph;
		disp_pkg::kind_e kind;
		logic [3:0] cnt;       // Bits seen in current byte
		logic [7:0] sh;        // Serial shift register
		logic rw;              // Current transfer is a read
		logic more;            // Chain flag of last control byte
		logic dc;              // Select flag of last control byte
		logic nack;            // Master refused last byte
		logic oe;              // Pulling the data line low
		disp_pkg::pend_e pend; // Second byte of a double command
		logic [7:0] col;
		logic [4:0] page;
		logic vert;            // Vertical addressing mode
		logic [7:0] contrast;
		logic segr;
		logic entire;
		logic inv;
		logic disp_on;
		logic scanr;
		logic en;              // Link enabled by software
		logic [7:0] line;      // Display line queried over APB
		logic [7:0] osc_cnt;
		logic tick;
		logic scl_p;
		logic sda_p;
		logic ext_p;
		logic ram_we;
		logic [11:0] ram_wa;
		logic [7:0] ram_wd;
		logic rdy;
		logic [31:0] rdata;
		logic slverr;
	} state_s;
	state_s q;
	state_s n;

	logic [4:0] sy;
	logic scl;
	logic sda;
	logic sa0;
	logic osc;
	logic ext;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic addr_hit;
	logic [11:0] idx;
	logic [7:0] ram_rd_q;
	logic [7:0] com_idx;

	// Bit-mapped display store, 20 pages of 160 bytes
	logic [7:0] ram [0:disp_pkg::RAM_BYTES-1];

	// All pins pass two flops before use
	pin_sync #(.W(5)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in({ext_display_tick_in, osc_enable_select, slave_addr_low_bit_pin, sda_in, scl_in}),
		.pin_out(sy)
	);

	assign scl = sy[0];
	assign sda = sy[1];
	assign sa0 = sy[2];
	assign osc = sy[3];
	assign ext = sy[4];
	assign scl_rise = scl & ~q.scl_p;
	assign scl_fall = ~scl & q.scl_p;
	// Data edges while the clock stays high frame a transfer
	assign start_c = scl & q.scl_p & ~sda & q.sda_p;
	assign stop_c = scl & q.scl_p & sda & ~q.sda_p;
	// Strap supplies the low address bit
	assign addr_hit = (q.sh[7:1] == {disp_pkg::SLAVE_ADDR_HI, sa0}) && q.en;
	assign idx = 12'(q.page) * disp_pkg::PAGE_BYTES + 12'(q.col);
	// Common output for the queried line, reversed when scan flips
	assign com_idx = q.scanr ? disp_pkg::LINE_LAST - q.line : q.line;

	// Next state: display tick, link engine, command decoder, APB
	always_comb
	begin
		logic adv;
		logic load_tx;
		logic [7:0] txb;
		n = q;
		adv = 1'b0;
		load_tx = 1'b0;
		txb = q.dc ? ram_rd_q : (8'({7'h00, ~q.disp_on}) << disp_pkg::STAT_OFF_BIT);
		n.tick = 1'b0;
		n.ram_we = 1'b0;
		n.scl_p = scl;
		n.sda_p = sda;
		n.ext_p = ext;
		// Internal divider when selected, else external edges
		if (osc)
		begin
			if (q.osc_cnt == 8'(OSC_DIV - 1))
			begin
				n.osc_cnt = 8'h00;
				n.tick = 1'b1;
			end
			else
				n.osc_cnt = q.osc_cnt + 8'h01;
		end
		else
		begin
			n.osc_cnt = 8'h00;
			n.tick = ext & ~q.ext_p;
		end
		// Start restarts address phase from any state
		if (start_c)
		begin
			n.ph = disp_pkg::PH_RX;
			n.kind = disp_pkg::K_ADDR;
			n.cnt = 4'h0;
			n.oe = 1'b0;
		end
		else if (stop_c)
		begin
			// Select flag is kept for a later read
			n.ph = disp_pkg::PH_IDLE;
			n.oe = 1'b0;
		end
		else
		begin
			case (q.ph)
				disp_pkg::PH_RX:
				begin
					if (scl_rise)
					begin
						n.sh = {q.sh[6:0], sda};
						n.cnt = q.cnt + 4'h1;
					end
					else if (scl_fall && q.cnt == disp_pkg::BYTE_BITS)
					begin
						// Acknowledge each whole byte, except a foreign address byte
						n.oe = 1'b1;
						n.ph = disp_pkg::PH_ACK;
						case (q.kind)
							disp_pkg::K_ADDR:
							begin
								if (addr_hit)
								begin
									n.rw = q.sh[0];
									n.kind = disp_pkg::K_CTRL;
								end
								else
								begin
									// Foreign address: stay silent until next start
									n.oe = 1'b0;
									n.ph = disp_pkg::PH_IGNORE;
								end
							end
							disp_pkg::K_CTRL:
							begin
								n.more = q.sh[7];
								n.dc = q.sh[6];
								n.kind = disp_pkg::K_DATA;
							end
							disp_pkg::K_DATA:
							begin
								// Chain set: one data byte then another control
								n.kind = q.more ? disp_pkg::K_CTRL : disp_pkg::K_DATA;
								if (q.dc)
								begin
									n.ram_we = 1'b1;
									n.ram_wa = idx;
									n.ram_wd = q.sh;
									adv = 1'b1;
								end
								else if (q.pend == disp_pkg::P_CONTRAST)
								begin
									n.contrast = q.sh;
									n.pend = disp_pkg::P_NONE;
								end
								else if (q.pend == disp_pkg::P_PAGE)
								begin
									// Out of range page numbers are dropped
									if (q.sh[4:0] <= disp_pkg::PAGE_LAST && q.sh[7:5] == 3'h0)
										n.page = q.sh[4:0];
									n.pend = disp_pkg::P_NONE;
								end
								else if (q.sh[7:4] == disp_pkg::CMD_COL_LO)
									n.col = {q.col[7:4], q.sh[3:0]};
								else if (q.sh[7:4] == disp_pkg::CMD_COL_HI && q.sh[3:0] <= disp_pkg::COL_HI_MAX)
									n.col = {q.sh[3:0], q.col[3:0]};
								else
								begin
									case (q.sh)
										disp_pkg::CMD_MODE_PAGE: n.vert = 1'b0;
										disp_pkg::CMD_MODE_VERT: n.vert = 1'b1;
										disp_pkg::CMD_CONTRAST: n.pend = disp_pkg::P_CONTRAST;
										disp_pkg::CMD_PAGE_SET: n.pend = disp_pkg::P_PAGE;
										disp_pkg::CMD_SEG_NORM, disp_pkg::CMD_SEG_REV: n.segr = q.sh[0];
										disp_pkg::CMD_ALL_OFF, disp_pkg::CMD_ALL_ON: n.entire = q.sh[0];
										disp_pkg::CMD_NORMAL, disp_pkg::CMD_INVERSE: n.inv = q.sh[0];
										disp_pkg::CMD_DISP_OFF, disp_pkg::CMD_DISP_ON: n.disp_on = q.sh[0];
										disp_pkg::CMD_SCAN_NORM: n.scanr = 1'b0;
										disp_pkg::CMD_SCAN_REV: n.scanr = 1'b1;
										default: ;
									endcase
								end
							end
							default: ;
						endcase
					end
				end
				disp_pkg::PH_ACK:
				begin
					if (scl_fall)
					begin
						n.cnt = 4'h0;
						n.oe = 1'b0;
						n.ph = disp_pkg::PH_RX;
						// A read starts sending right after the address acknowledge
						load_tx = q.rw;
					end
				end
				disp_pkg::PH_TX:
				begin
					if (scl_fall)
					begin
						if (q.cnt == disp_pkg::LAST_TX_BIT)
						begin
							n.oe = 1'b0;
							n.ph = disp_pkg::PH_TXACK;
						end
						else
						begin
							n.cnt = q.cnt + 4'h1;
							n.sh = {q.sh[6:0], 1'b0};
							n.oe = ~q.sh[6];
						end
					end
				end
				disp_pkg::PH_TXACK:
				begin
					if (scl_rise)
						n.nack = sda;
					else if (scl_fall)
					begin
						if (q.nack)
							n.ph = disp_pkg::PH_IGNORE;
						else
							load_tx = 1'b1;
					end
				end
				default: ;
			endcase
		end
		// Load the next byte to send and drive its first bit
		if (load_tx)
		begin
			n.ph = disp_pkg::PH_TX;
			n.cnt = 4'h0;
			n.sh = txb;
			n.oe = ~txb[7];
			adv = q.dc;
		end
		// Column and page step separately, never carry into each other
		if (adv)
		begin
			if (!q.vert)
				n.col = (q.col == disp_pkg::COL_LAST) ? disp_pkg::COL_FIRST : q.col + 8'h01;
			else
				n.page = (q.page == disp_pkg::PAGE_LAST) ? disp_pkg::PAGE_FIRST : q.page + 5'h01;
		end
		// APB: answer in the first access cycle, unmapped reads give an error
		n.rdy = 1'b0;
		n.slverr = 1'b0;
		if (psel && !penable)
		begin
			n.rdy = 1'b1;
			n.rdata = 32'h00000000;
			case (paddr)
				disp_pkg::REG_CTRL:
				begin
					n.rdata[disp_pkg::CTRL_EN_BIT] = q.en;
					n.rdata[disp_pkg::CTRL_SCAN_BIT] = q.scanr;
				end
				disp_pkg::REG_STATUS:
				begin
					n.rdata[disp_pkg::ST_PAGE_LSB +: 5] = q.page;
					n.rdata[disp_pkg::ST_COL_LSB +: 8] = q.col;
					n.rdata[disp_pkg::ST_VERT_BIT] = q.vert;
					n.rdata[disp_pkg::ST_DC_BIT] = q.dc;
					n.rdata[disp_pkg::ST_BUSY_BIT] = (q.ph != disp_pkg::PH_IDLE);
					n.rdata[disp_pkg::ST_COM_LSB +: 8] = com_idx;
				end
				disp_pkg::REG_SETTINGS:
				begin
					n.rdata[7:0] = q.contrast;
					n.rdata[disp_pkg::SET_SEG_BIT] = q.segr;
					n.rdata[disp_pkg::SET_ALL_BIT] = q.entire;
					n.rdata[disp_pkg::SET_INV_BIT] = q.inv;
					n.rdata[disp_pkg::SET_ON_BIT] = q.disp_on;
					n.rdata[disp_pkg::SET_MUX_LSB +: 8] = disp_pkg::MUX_RST;
				end
				disp_pkg::REG_LINE: n.rdata[7:0] = q.line;
				default: n.slverr = 1'b1;
			endcase
		end
		if (psel && penable && q.rdy && pwrite)
		begin
			case (paddr)
				disp_pkg::REG_CTRL:
				begin
					n.en = pwdata[disp_pkg::CTRL_EN_BIT];
					n.scanr = pwdata[disp_pkg::CTRL_SCAN_BIT];
				end
				disp_pkg::REG_LINE: n.line = pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Register the state; reset gives display off and default mapping
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q <= '0;
			q.contrast <= disp_pkg::CONTRAST_RST;
			q.en <= 1'b1;
		end
		else
			q <= n;
	end

	// RAM write and registered read at the pointer
	always_ff @(posedge pclk)
	begin
		if (q.ram_we)
			ram[q.ram_wa] <= q.ram_wd;
		ram_rd_q <= ram[idx];
	end

	assign prdata = q.rdata;
	assign pready = q.rdy;
	assign pslverr = q.slverr;
	// Open drain: the line is only ever pulled low
	assign sda_out = 1'b0;
	assign sda_oe = q.oe;
	assign display_tick = q.tick;
	assign panel_drive_en = q.disp_on;
	assign scan_reverse = q.scanr;
	assign seg_remap = q.segr;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_addr_done;
		q.ph == disp_pkg::PH_RX && q.kind == disp_pkg::K_ADDR && scl_fall && q.cnt == 4'h8 && !start_c && !stop_c;
	endsequence
	sequence s_ctrl_done;
		q.ph == disp_pkg::PH_RX && q.kind == disp_pkg::K_CTRL && scl_fall && q.cnt == 4'h8 && !start_c && !stop_c;
	endsequence
	sequence s_data_done;
		q.ph == disp_pkg::PH_RX && q.kind == disp_pkg::K_DATA && scl_fall && q.cnt == 4'h8 && !start_c && !stop_c;
	endsequence

	AST_ADDR_MATCH_ACK: assert property (s_addr_done ##0 addr_hit |=> q.ph == disp_pkg::PH_ACK && sda_oe) else $error("matched address not acknowledged");
	AST_ADDR_MISS: assert property (s_addr_done ##0 !addr_hit |=> q.ph == disp_pkg::PH_IGNORE && !sda_oe) else $error("foreign address not ignored");
	AST_IGNORE_QUIET: assert property (q.ph == disp_pkg::PH_IGNORE |-> !sda_oe && !q.ram_we) else $error("ignored transfer drove bus or RAM");
	AST_CTRL_FLAGS: assert property (s_ctrl_done |=> q.more == $past(q.sh[7]) && q.dc == $past(q.sh[6]) && q.kind == disp_pkg::K_DATA) else $error("control byte flags wrong");
	AST_CHAIN_NEXT: assert property (s_data_done ##0 q.more |=> q.kind == disp_pkg::K_CTRL) else $error("chain set but no control byte expected");
	AST_CHAIN_END: assert property (s_data_done ##0 !q.more |=> q.kind == disp_pkg::K_DATA) else $error("chain clear but control byte expected");
	AST_RAM_ROUTE: assert property (s_data_done ##0 q.dc |=> q.ram_we && q.ram_wd == $past(q.sh)) else $error("RAM byte not written");
	AST_CMD_ROUTE: assert property (s_data_done ##0 !q.dc |=> !q.ram_we) else $error("command byte reached RAM");
	AST_COL_STEP: assert property (s_data_done ##0 (q.dc && !q.vert) |=> q.page == $past(q.page) && q.col == ($past(q.col) == 8'h9F ? 8'h00 : $past(q.col) + 8'h01)) else $error("column step wrong");
	AST_PAGE_STEP: assert property (s_data_done ##0 (q.dc && q.vert) |=> q.col == $past(q.col) && q.page == ($past(q.page) == 5'h13 ? 5'h00 : $past(q.page) + 5'h01)) else $error("page step wrong");
	AST_READ_START: assert property (q.ph == disp_pkg::PH_ACK && scl_fall && q.rw && !start_c && !stop_c |=> q.ph == disp_pkg::PH_TX ##1 q.ph == disp_pkg::PH_TX) else $error("read did not start");
	AST_NACK_STOP: assert property (q.ph == disp_pkg::PH_TXACK && scl_fall && q.nack && !start_c && !stop_c |=> !sda_oe [*2]) else $error("line not released after no-acknowledge");
	AST_STOP_IDLE: assert property (stop_c && !start_c |=> q.ph == disp_pkg::PH_IDLE && !sda_oe && q.dc == $past(q.dc)) else $error("stop did not return idle");
	AST_EXT_TICK: assert property (!osc && ext && !q.ext_p |=> display_tick) else $error("external tick lost");
endmodule
`default_nettype wire

// ### dv/i2c_host_model.sv
// Two-wire bus master model that clocks bytes into and out of the display port
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
	input wire logic pclk,
	input wire logic sda_oe,
	output logic scl,
	output logic sda
);
	logic scl_q = 1'b1; // Clock stands high between frames
	logic sda_q = 1'b1; // Released data floats to the pull-up
	assign scl = scl_q;
	// Wired-and: either side pulling low wins over the pull-up
	assign sda = sda_q & ~sda_oe;
	task wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// Data falls while clock is high
	task start();
		sda_q <= 1'b1;
		scl_q <= 1'b1;
		wt(2);
		sda_q <= 1'b0;
		wt(4);
		scl_q <= 1'b0;
		wt(2);
	endtask
	// Data rises while clock is high
	task stop();
		sda_q <= 1'b0;
		wt(2);
		scl_q <= 1'b1;
		wt(4);
		sda_q <= 1'b1;
		wt(4);
	endtask
	// Data changes two cycles after the fall, so the slave never sees it as a condition
	task bit_io(input logic b, output logic s);
		sda_q <= b;
		wt(2);
		scl_q <= 1'b1;
		wt(4);
		s = sda;
		scl_q <= 1'b0;
		wt(2);
	endtask
	// Byte out, most significant first, then the ninth clock for the answer
	task wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask
	// Byte in with the line released, then our own acknowledge or not
	task rd_byte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(nack, s);
	endtask
endmodule
`default_nettype wire

// ### dv/disp_i2c_port_test.sv
// Self-checking bench for the display port two-wire front end
`timescale 1ns/1ps
`default_nettype none
module disp_i2c_port_test;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic scl;
	logic sda;
	logic sda_oe;
	logic strap = 1'b0; // Address low bit strap
	logic osc_sel = 1'b1; // Internal tick first
	logic ext_tick = 1'b0;
	logic display_tick;
	logic panel_drive_en;
	logic scan_reverse;
	logic seg_remap;
	int err_count = 0;
	int checks = 0;
	int ticks = 0;
	// Rows: command, register, bit, expected bit
	logic [31:0] rows [12] = '{32'hA1080801, 32'hA0080800, 32'hA5080901, 32'hA4080900,
		32'hA7080A01, 32'hA6080A00, 32'hAF080B01, 32'hAE080B00, 32'h21041001, 32'h20041000,
		32'hC8000101, 32'hC0000100};
	always #25 pclk = ~pclk;
	// Counted on the falling edge so reads at the rising edge never race it
	always @(negedge pclk)
		if (display_tick === 1'b1) ticks++;
	disp_i2c_port #(.OSC_DIV(4)) i_disp_i2c_port (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda), .sda_out(),
		.sda_oe(sda_oe), .slave_addr_low_bit_pin(strap), .osc_enable_select(osc_sel),
		.ext_display_tick_in(ext_tick), .display_tick(display_tick),
		.panel_drive_en(panel_drive_en), .scan_reverse(scan_reverse), .seg_remap(seg_remap));
	i2c_host_model i_i2c_host_model (.pclk(pclk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
	task close_out();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	// One transfer: setup, access held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	// Address byte then n bytes taken from the top of b
	task send(input logic [7:0] ad, input logic [63:0] b, input int n, input logic ex);
		logic a;
		i_i2c_host_model.start();
		i_i2c_host_model.wr_byte(ad, a);
		chk("addr ack", a, ex);
		for (int i = 0; i < n; i++)
		begin
			i_i2c_host_model.wr_byte(b[63-8*i -: 8], a);
			chk("byte ack", a, ex);
		end
		i_i2c_host_model.stop();
	endtask
	initial
	begin : watchdog
		repeat (80000) @(posedge pclk);
		err_count++;
		close_out();
	end
	initial
	begin : main_seq
		logic [31:0] r;
		logic [7:0] d;
		logic a;
		int t0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("drive en", panel_drive_en, 32'h0);
		chk("seg pin", seg_remap, 32'h0);
		rd(8'h08, r);
		chk("settings", r, 32'h009F0080);
		rd(8'h04, r);
		chk("status", r, 32'h0);
		apb(1'b0, 8'h10, 32'h0, r, a);
		chk("slverr", a, 32'h1);
		// Each command through a final control byte with select low
		for (int i = 0; i < 12; i++)
		begin
			send(8'h78, {8'h00, rows[i][31:24], 48'h0}, 2, 1'b1);
			rd(rows[i][23:16], r);
			chk("setting bit", r[rows[i][15:8]], rows[i][0]);
			// Segment map commands must also reach the pin
			if (rows[i][31:25] == 7'h50)
				chk("seg pin", seg_remap, rows[i][0]);
		end
		send(8'h78, {32'h00813CAF, 32'h0}, 4, 1'b1);
		rd(8'h08, r);
		chk("contrast", r[7:0], 32'h3C);
		chk("drive en", panel_drive_en, 32'h1);
		// Foreign address, then link disabled: nothing may change
		send(8'h7A, {24'h008111, 40'h0}, 3, 1'b0);
		wr(8'h00, 32'h0);
		send(8'h78, {24'h008122, 40'h0}, 3, 1'b0);
		wr(8'h00, 32'h1);
		rd(8'h08, r);
		chk("contrast", r[7:0], 32'h3C);
		strap <= 1'b1;
		repeat (4) @(posedge pclk);
		send(8'h7A, {24'h008155, 40'h0}, 3, 1'b1);
		send(8'h78, {24'h008166, 40'h0}, 3, 1'b0);
		rd(8'h08, r);
		chk("contrast", r[7:0], 32'h55);
		strap <= 1'b0;
		repeat (4) @(posedge pclk);
		// Page 2 column 15H, then two chained bytes of RAM data
		send(8'h78, {40'h00B0021105, 24'h0}, 5, 1'b1);
		send(8'h78, {32'hC0A5403C, 32'h0}, 4, 1'b1);
		rd(8'h04, r);
		chk("pointer", r & 32'h0007FFFF, 32'h00021702);
		send(8'h78, {24'h001105, 40'h0}, 3, 1'b1);
		send(8'h78, {8'h40, 56'h0}, 1, 1'b1);
		i_i2c_host_model.start();
		i_i2c_host_model.wr_byte(8'h79, a);
		chk("read ack", a, 32'h1);
		i_i2c_host_model.rd_byte(1'b0, d);
		chk("ram byte", d, 32'hA5);
		i_i2c_host_model.rd_byte(1'b1, d);
		chk("ram byte", d, 32'h3C);
		repeat (16) @(posedge pclk);
		chk("released", sda_oe, 32'h0);
		i_i2c_host_model.stop();
		send(8'h78, {16'h00AE, 48'h0}, 2, 1'b1);
		i_i2c_host_model.start();
		i_i2c_host_model.wr_byte(8'h79, a);
		i_i2c_host_model.rd_byte(1'b1, d);
		chk("status off", d, 32'h40);
		i_i2c_host_model.stop();
		// Column wraps at 9FH in page mode
		send(8'h78, {24'h00190F, 40'h0}, 3, 1'b1);
		send(8'h78, {16'h4077, 48'h0}, 2, 1'b1);
		rd(8'h04, r);
		chk("col wrap", r & 32'h0001FFFF, 32'h00000002);
		send(8'h78, {32'h0021B012, 32'h0}, 4, 1'b1);
		send(8'h78, {24'h400102, 40'h0}, 3, 1'b1);
		rd(8'h04, r);
		chk("page wrap", r & 32'h0001FFFF, 32'h00010000);
		wr(8'h0C, 32'h5);
		rd(8'h04, r);
		chk("common", r[31:24], 32'h05);
		wr(8'h00, 32'h3);
		rd(8'h04, r);
		chk("common rev", r[31:24], 32'h9A);
		chk("scan rev", scan_reverse, 32'h1);
		wr(8'h00, 32'h1);
		// Internal divider, then a stopped and a toggled external tick
		t0 = ticks;
		repeat (40) @(posedge pclk);
		chk("osc ticks", (ticks - t0 >= 9) && (ticks - t0 <= 11), 32'h1);
		osc_sel <= 1'b0;
		repeat (10) @(posedge pclk);
		t0 = ticks;
		repeat (40) @(posedge pclk);
		chk("ext idle", ticks - t0, 32'h0);
		repeat (8)
		begin
			ext_tick <= 1'b1;
			repeat (5) @(posedge pclk);
			ext_tick <= 1'b0;
			repeat (5) @(posedge pclk);
		end
		repeat (5) @(posedge pclk);
		chk("ext ticks", ticks - t0, 32'h8);
		// Reset in mid-run with display on and column moved
		send(8'h78, {24'h00AF13, 40'h0}, 3, 1'b1);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("drive en", panel_drive_en, 32'h0);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		rd(8'h08, r);
		chk("settings", r, 32'h009F0080);
		rd(8'h04, r);
		chk("column", r & 32'h0000FFFF, 32'h0);
		close_out();
	end
endmodule
`default_nettype wire
